// File: sim/scg_clock_gen_props.sv
// Purpose: port relations of the clock generation block
// Assumes: one pclk domain, presetn async low
// Notes:   multiplied clocks seen as ratio outputs only
module scg_clock_gen_props (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // observed outputs
  input wire logic       rcw_valid,
  input wire logic       mem_bus_clock_pair_p,
  input wire logic       mem_bus_clock_pair_n,
  input wire logic       local_sync_clock_out,
  input wire logic [2:0] local_bus_clock_outs,
  input wire logic [3:0] system_pll_multiplier,
  input wire logic [4:0] csb_mult,
  input wire logic [1:0] ddr_clk_mult,
  input wire logic [1:0] lbiu_clk_mult,
  input wire logic       core_pll_bypass,
  input wire logic [3:0] core_ratio_x2,
  input wire logic [3:0] core_vco_div,
  input wire logic       core_cfg_invalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // capture of the reset word
  sequence s_settle;
    !rcw_valid[*3] ##[1:2] rcw_valid;
  endsequence
  chk_word_capture: assert property ($rose(presetn) |-> s_settle)
    else $error("reset word capture timing wrong");
  // ==========================================================
  // derived clocks
  chk_mem_pair_comp: assert property (
    rcw_valid |-> mem_bus_clock_pair_n != mem_bus_clock_pair_p)
    else $error("memory clock pair not complementary");
  chk_mem_half_rate: assert property (
    rcw_valid |-> mem_bus_clock_pair_p != $past(mem_bus_clock_pair_p))
    else $error("memory clock not pclk halved");
  chk_local_same: assert property (
    local_bus_clock_outs == {3{local_sync_clock_out}})
    else $error("local clocks differ from sync out");
  chk_ddr_mult_set: assert property (ddr_clk_mult inside {2'h1, 2'h2})
    else $error("memory multiple out of set");
  chk_lbiu_mult_set: assert property (lbiu_clk_mult inside {2'h1, 2'h2})
    else $error("local unit multiple out of set");
  chk_csb_mult_rel: assert property (
    csb_mult == {1'b0, system_pll_multiplier} ||
    csb_mult == {system_pll_multiplier, 1'b0})
    else $error("bus multiple not one or two times pll");
  // ==========================================================
  // core pll decode
  chk_bypass_zero: assert property (
    core_pll_bypass |-> core_ratio_x2 == 4'h0 && core_vco_div == 4'h0)
    else $error("bypass with ratio or divider set");
  chk_vco_set: assert property (
    !core_pll_bypass |-> core_vco_div inside {4'h2, 4'h4, 4'h8})
    else $error("core divider out of set");
  chk_ratio_set: assert property (
    !core_pll_bypass && !core_cfg_invalid |->
    core_ratio_x2 inside {[4'h2:4'h6]})
    else $error("core ratio out of set");
endmodule
bind scg_clock_gen scg_clock_gen_props u_props (
  .pclk(pclk), .presetn(presetn), .rcw_valid(rcw_valid),
  .mem_bus_clock_pair_p(mem_bus_clock_pair_p),
  .mem_bus_clock_pair_n(mem_bus_clock_pair_n),
  .local_sync_clock_out(local_sync_clock_out),
  .local_bus_clock_outs(local_bus_clock_outs),
  .system_pll_multiplier(system_pll_multiplier), .csb_mult(csb_mult),
  .ddr_clk_mult(ddr_clk_mult), .lbiu_clk_mult(lbiu_clk_mult),
  .core_pll_bypass(core_pll_bypass), .core_ratio_x2(core_ratio_x2),
  .core_vco_div(core_vco_div), .core_cfg_invalid(core_cfg_invalid));

// File: sim/scg_clock_gen_tb_top.sv
// Purpose: self-checking bench for the clock generation block
// Assumes: apb master on pclk, oscillator model for the pins
// Notes:   clock rates judged by edge counts, unit enables by high-cycle counts, over fixed windows
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module scg_clock_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] HARD_WORD = 32'h4307_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rcw_pins, rd;
  logic [3:0]  pstrb, system_pll_multiplier, core_ratio_x2, core_vco_div;
  logic        host_clk_pin, bus_clk_pin, bus_agent_mode, er;
  logic        clkin_halve_strap, rcw_from_hard, bus_sync_clk_out;
  logic [4:0]  bus_clk_outs, unit_clk_en, csb_mult;
  logic        mem_bus_clock_pair_p, mem_bus_clock_pair_n;
  logic        local_sync_clock_out, pci_dma_clk_en, rcw_valid;
  logic [2:0]  local_bus_clock_outs;
  logic [1:0]  ddr_clk_mult, lbiu_clk_mult;
  logic        core_pll_bypass, core_cfg_invalid;
  logic [9:0]  w, prev_w;
  int          n_errors, num_checks, cyc;
  int          cnt [10];
  int          base [10];
  int          d [10];
  // ==========================================================
  // design and oscillator
  scg_clock_gen #(.HARD_RESET_CONFIG_WORD_LOW(HARD_WORD)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .host_clk_pin(host_clk_pin),
    .bus_clk_pin(bus_clk_pin), .bus_agent_mode(bus_agent_mode),
    .clkin_halve_strap(clkin_halve_strap), .rcw_from_hard(rcw_from_hard),
    .rcw_pins(rcw_pins), .bus_sync_clk_out(bus_sync_clk_out),
    .bus_clk_outs(bus_clk_outs), .mem_bus_clock_pair_p(mem_bus_clock_pair_p),
    .mem_bus_clock_pair_n(mem_bus_clock_pair_n),
    .local_sync_clock_out(local_sync_clock_out),
    .local_bus_clock_outs(local_bus_clock_outs), .unit_clk_en(unit_clk_en),
    .pci_dma_clk_en(pci_dma_clk_en), .rcw_valid(rcw_valid),
    .system_pll_multiplier(system_pll_multiplier), .csb_mult(csb_mult),
    .ddr_clk_mult(ddr_clk_mult), .lbiu_clk_mult(lbiu_clk_mult),
    .core_pll_bypass(core_pll_bypass), .core_ratio_x2(core_ratio_x2),
    .core_vco_div(core_vco_div), .core_cfg_invalid(core_cfg_invalid));
  scg_osc_model osc (.host_clk_pin(host_clk_pin), .bus_clk_pin(bus_clk_pin));
  // ==========================================================
  // clock, edge counters, hang guard
  always #25 pclk = ~pclk;
  assign w = {unit_clk_en, mem_bus_clock_pair_p, local_sync_clock_out,
              bus_clk_outs[1:0], bus_sync_clk_out};
  always @(posedge pclk) begin
    prev_w <= w;
    for (int i = 0; i < 10; i++) begin
      cnt[i] <= cnt[i] + ((i < 5) ? int'(w[i] & !prev_w[i]) : int'(w[i]));
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic window(input int n);
    base = cnt;
    repeat (n) @(posedge pclk);
    foreach (d[i]) d[i] = cnt[i] - base[i];
  endtask
  task automatic near(input string nm, input int got, input int e);
    num_checks++;
    if (got < e - 1 || got > e + 1) begin
      n_errors++;
      $display("BAD %s exp %0d got %0d", nm, e, got);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    apb(1'b0, scg_pkg::OFF_OUTC, 32'h0);
    `CHK("out ctl", 32'h0, rd)
    apb(1'b0, scg_pkg::OFF_SYSC, 32'h0);
    `CHK("unit ctl", 32'h7ff, rd)
    `CHK("dma", 1'b1, pci_dma_clk_en)
    apb(1'b0, scg_pkg::OFF_LOCC, 32'h0);
    `CHK("local ctl", 32'h0, rd)
    apb(1'b1, 8'h14, 32'hffff_ffff);
    `CHK("unmapped", 1'b1, er)
  endtask
  task automatic t_units();
    window(60);
    for (int i = 5; i < 10; i++) near("third", d[i], 20);
    apb(1'b1, scg_pkg::OFF_SYSC, 32'h2c9);
    repeat (8) @(posedge pclk);
    window(60);
    near("full", d[5], 60);
    near("half", d[6], 30);
    `CHK("off", 0, d[7])
    near("third", d[8], 20);
    near("half", d[9], 30);
    `CHK("dma off", 1'b0, pci_dma_clk_en)
    apb(1'b1, scg_pkg::OFF_SYSC, 32'h7ff);
  endtask
  task automatic t_bus(input logic ag, input logic hv, input logic [4:0] oc,
                       input int e_sync, input int e0, input int e1);
    bus_agent_mode <= ag;
    clkin_halve_strap <= hv;
    apb(1'b1, scg_pkg::OFF_OUTC, {27'h0, oc});
    repeat (40) @(posedge pclk);
    window(480);
    near("sync out", d[0], e_sync);
    near("bus out0", d[1], e0);
    near("bus out1", d[2], e1);
    // outputs sharing a select share a waveform; oc[0] differs from oc[1]
    repeat (24) begin
      @(posedge pclk);
      for (int j = 2; j < 5; j++) begin
        `CHK("bus hi", bus_clk_outs[oc[j] ^ oc[0]], bus_clk_outs[j])
      end
    end
  endtask
  task automatic t_lclk();
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, scg_pkg::OFF_LOCC, 32'(k));
      repeat (16) @(posedge pclk);
      window(64);
      near("local", d[3], (k == 0) ? 32 : (k == 1) ? 16 : 8);
      near("mem pair", d[4], 32);
    end
  endtask
  task automatic t_decode();
    logic [6:0]  cores [7];
    logic [6:0]  c;
    logic [31:0] wd;
    logic        h;
    cores = '{7'h00, 7'h04, 7'h45, 7'h0a, 7'h4b, 7'h0c, 7'h4c};
    for (int i = 0; i < 8; i++) begin
      wd = (i == 7) ? HARD_WORD
         : {i[0], i[1], 2'b00, 4'(i + 2), 1'b0, cores[i % 7], 16'h0};
      h = (i == 7) ? 1'b0 : i[0] ^ i[1];
      c = wd[22:16];
      presetn <= 1'b0;
      rcw_pins <= (i == 7) ? 32'h0 : wd;
      rcw_from_hard <= (i == 7);
      clkin_halve_strap <= h;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK("valid", 1'b1, rcw_valid)
      `CHK("sys mult", wd[27:24], system_pll_multiplier)
      `CHK("csb", 5'(wd[27:24] * (1 + h)), csb_mult)
      `CHK("ddr", 2'(1 + wd[30]), ddr_clk_mult)
      `CHK("lbiu", 2'(1 + wd[31]), lbiu_clk_mult)
      `CHK("bypass", c[5:2] == 4'h0, core_pll_bypass)
      if (c[5:2] != 4'h0) begin
        `CHK("invalid", c == 7'h4c, core_cfg_invalid)
        `CHK("vco", c[1] ? 4'h8 : c[0] ? 4'h4 : 4'h2, core_vco_div)
        if (c != 7'h4c)
          `CHK("ratio", 4'(2 * c[5:2] + c[6]), core_ratio_x2)
      end
      apb(1'b0, scg_pkg::OFF_RCFG, 32'h0);
      `CHK("word", wd, rd)
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, bus_agent_mode, clkin_halve_strap} = 5'h00;
    {paddr, pwdata, pstrb, rcw_pins, rcw_from_hard} = 77'h0;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_units();
    t_bus(1'b0, 1'b0, 5'h05, 30, 15, 30);
    t_bus(1'b1, 1'b1, 5'h02, 10, 20, 10);
    t_lclk();
    t_decode();
    print_verdict();
  end
endmodule

// File: sim/scg_osc_model.sv
// Purpose: board oscillator and bus clock source
// Assumes: free-running sources, phase unrelated to pclk
// Notes:   rates scaled well below pclk/2 for the synchronisers
module scg_osc_model #(
  parameter int HOST_HALF = 400,
  parameter int BUS_HALF  = 600
) (
  // source clocks
  output logic host_clk_pin,
  output logic bus_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // sources; real inputs sit in 25..66 MHz
  initial begin
    host_clk_pin = 1'b0;
    #13;
    forever #HOST_HALF host_clk_pin = ~host_clk_pin;
  end
  initial begin
    bus_clk_pin = 1'b0;
    #31;
    forever #BUS_HALF bus_clk_pin = ~bus_clk_pin;
  end
endmodule

// File: src/scg_clock_gen.sv
// Purpose: clock selection, division and ratio control for the soc
// Assumes: pclk stands in for the system bus clock; pins are async
// Notes:   multiplied clocks are reported as ratios, not synthesised
//
// Register access over APB and the register addresses were chosen for this implementation.

// Behaviour
// - primary clock is the clock pin in host mode, bus clock in agent.
// - sync clock out is primary or primary halved per halving strap.
// - each bus clock out is primary or half, per its select bit.
// - system bus multiple is (1 + halving strap) times pll multiplier.
// - pll multiplier and core setting come from the reset word.
// - memory clock is bus times (1+doubler); pair is it halved.
// - local bus unit clock is one or two times the bus clock.
// - local clocks are the unit clock divided by two, four or eight.
// - units default to one third rate; each off, full or half.
// - core ratio bits all zero bypass the core pll.
// - ratio 1, 2, 3 give 1:1, 2:1, 3:1; bit 6 adds a half.
// - divider bits 00 give 2, 01 give 4, otherwise 8.
module scg_clock_gen #(
  parameter logic [31:0] HARD_RESET_CONFIG_WORD_LOW = 32'h0000_0000
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // clock pins and straps
  input  wire logic        host_clk_pin,
  input  wire logic        bus_clk_pin,
  input  wire logic        bus_agent_mode,
  input  wire logic        clkin_halve_strap,
  input  wire logic        rcw_from_hard,
  input  wire logic [31:0] rcw_pins,
  // bus clock outputs
  output logic             bus_sync_clk_out,
  output logic [4:0]       bus_clk_outs,
  // memory and local bus clocks
  output logic             mem_bus_clock_pair_p,
  output logic             mem_bus_clock_pair_n,
  output logic             local_sync_clock_out,
  output logic [2:0]       local_bus_clock_outs,
  // unit clock enables
  output logic [4:0]       unit_clk_en,
  output logic             pci_dma_clk_en,
  // decoded configuration
  output logic             rcw_valid,
  output logic [3:0]       system_pll_multiplier,
  output logic [4:0]       csb_mult,
  output logic [1:0]       ddr_clk_mult,
  output logic [1:0]       lbiu_clk_mult,
  output logic             core_pll_bypass,
  output logic [3:0]       core_ratio_x2,
  output logic [3:0]       core_vco_div,
  output logic             core_cfg_invalid
);

  // ==========================================================
  // pin synchronisers
  logic [1:0]  host_s_q;
  logic [1:0]  bus_s_q;
  logic [1:0]  agent_s_q;
  logic [1:0]  halve_s_q;
  logic [1:0]  hard_s_q;
  logic [31:0] rcw_s1_q;
  logic [31:0] rcw_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_s_q  <= 2'h0;
      bus_s_q   <= 2'h0;
      agent_s_q <= 2'h0;
      halve_s_q <= 2'h0;
      hard_s_q  <= 2'h0;
      rcw_s1_q  <= 32'h0;
      rcw_s2_q  <= 32'h0;
    end else begin
      host_s_q  <= {host_s_q[0], host_clk_pin};
      bus_s_q   <= {bus_s_q[0], bus_clk_pin};
      agent_s_q <= {agent_s_q[0], bus_agent_mode};
      halve_s_q <= {halve_s_q[0], clkin_halve_strap};
      hard_s_q  <= {hard_s_q[0], rcw_from_hard};
      rcw_s1_q  <= rcw_pins;
      rcw_s2_q  <= rcw_s1_q;
    end
  end

  // ==========================================================
  // reset word capture after release
  scg_pkg::scg_cap_type cap_q;
  scg_pkg::scg_cap_type cap_d;
  logic [1:0]           settle_q;
  logic [31:0]          rcw_q;
  logic                 halve_q;
  logic                 agent_q;
  wire                  cap_now = (cap_q == scg_pkg::CAP_SETTLE) &&
                                  (settle_q == scg_pkg::SETTLE_CYCLES);
  wire  [31:0]          rcw_src = hard_s_q[1] ? HARD_RESET_CONFIG_WORD_LOW : rcw_s2_q;

  always_comb begin
    cap_d = cap_q;
    unique case (cap_q)
      scg_pkg::CAP_SETTLE: begin
        if (cap_now) begin
          cap_d = scg_pkg::CAP_RUN;
        end
      end
      scg_pkg::CAP_RUN: begin
        cap_d = scg_pkg::CAP_RUN;
      end
      default: begin
        cap_d = scg_pkg::CAP_SETTLE;
      end
    endcase
  end

  // captured straps are held until the next power-on reset; clock select and sync halving follow the live straps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q    <= scg_pkg::CAP_SETTLE;
      settle_q <= 2'h0;
      rcw_q    <= 32'h0;
      halve_q  <= 1'b0;
      agent_q  <= 1'b0;
    end else begin
      cap_q <= cap_d;
      if (cap_q == scg_pkg::CAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
      if (cap_now) begin
        rcw_q   <= rcw_src;
        halve_q <= halve_s_q[1];
        agent_q <= agent_s_q[1];
      end
    end
  end

  // ==========================================================
  // configuration decode
  wire [3:0] sysm      = rcw_q[scg_pkg::RCW_SYSM_LSB +: scg_pkg::RCW_SYSM_W];
  wire [6:0] cpll      = rcw_q[scg_pkg::RCW_CPLL_LSB +: scg_pkg::RCW_CPLL_W];
  wire [1:0] vco_sel   = cpll[scg_pkg::CPLL_VCO_LSB +: 2];
  wire [3:0] rat_sel   = cpll[scg_pkg::CPLL_RAT_LSB +: 4];
  wire       rat_half  = cpll[scg_pkg::CPLL_HALF_BIT];
  wire       ddr_dbl   = rcw_q[scg_pkg::RCW_MEMDB_BIT];
  wire       lbiu_dbl  = rcw_q[scg_pkg::RCW_LBICM_BIT];

  wire       bypass_d  = (rat_sel == scg_pkg::CORE_RAT_BYPASS);
  wire       rat_ok    = (rat_sel == scg_pkg::CORE_RAT_1) ||
                         (rat_sel == scg_pkg::CORE_RAT_2) ||
                         (rat_sel == scg_pkg::CORE_RAT_3 && !rat_half);
  // ratio times two: 1->2/3, 2->4/5, 3->6
  wire [3:0] ratio_x2_d = bypass_d ? 4'h0 :
                          {rat_sel[2:0], rat_half};
  wire [3:0] vco_d      = (vco_sel == scg_pkg::VCO_SEL_2) ?
                          scg_pkg::VCO_DIV_2 :
                          (vco_sel == scg_pkg::VCO_SEL_4) ?
                          scg_pkg::VCO_DIV_4 : scg_pkg::VCO_DIV_8;
  wire [4:0] csb_mult_d = halve_q ? {sysm, 1'b0} : {1'b0, sysm};

  logic [3:0] sysm_q;
  logic [4:0] csb_mult_q;
  logic [1:0] ddr_mult_q;
  logic [1:0] lbiu_mult_q;
  logic       bypass_q;
  logic [3:0] ratio_x2_q;
  logic [3:0] vco_q;
  logic       invalid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysm_q      <= 4'h0;
      csb_mult_q  <= 5'h00;
      ddr_mult_q  <= 2'h1;
      lbiu_mult_q <= 2'h1;
      bypass_q    <= 1'b1;
      ratio_x2_q  <= 4'h0;
      vco_q       <= 4'h0;
      invalid_q   <= 1'b0;
    end else begin
      sysm_q      <= sysm;
      csb_mult_q  <= csb_mult_d;
      ddr_mult_q  <= ddr_dbl ? 2'h2 : 2'h1;
      lbiu_mult_q <= lbiu_dbl ? 2'h2 : 2'h1;
      bypass_q    <= bypass_d;
      ratio_x2_q  <= ratio_x2_d;
      vco_q       <= bypass_d ? 4'h0 : vco_d;
      invalid_q   <= !bypass_d && !rat_ok;
    end
  end

  // ==========================================================
  // primary clock and bus clock outputs
  logic       prim_q;
  logic       half_q;
  logic       sync_out_q;
  logic [4:0] bus_out_q;
  logic [4:0] outc_q;
  wire        prim_d = agent_s_q[1] ? bus_s_q[1] : host_s_q[1];
  wire        prim_rise = prim_d && !prim_q;
  wire [4:0]  bus_out_d = (outc_q & {5{half_q}}) |
                          (~outc_q & {5{prim_q}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_q     <= 1'b0;
      half_q     <= 1'b0;
      sync_out_q <= 1'b0;
      bus_out_q  <= 5'h00;
    end else begin
      prim_q     <= prim_d;
      if (prim_rise) begin
        half_q <= !half_q;
      end
      sync_out_q <= halve_s_q[1] ? half_q : prim_q;
      bus_out_q  <= bus_out_d;
    end
  end

  // ==========================================================
  // memory and local bus clocks
  // pclk plays ddr_clk and lbiu_clk; their multiples go out as ratios
  logic       mem_p_q;
  logic       mem_n_q;
  logic [2:0] lb_cnt_q;
  logic       lclk_q;
  logic [1:0] locc_q;
  // a divider change may shorten one local clock period
  wire        lclk_d = (locc_q == scg_pkg::LBDIV_2) ? lb_cnt_q[0] :
                       (locc_q == scg_pkg::LBDIV_4) ? lb_cnt_q[1] :
                       lb_cnt_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_p_q  <= 1'b0;
      mem_n_q  <= 1'b1;
      lb_cnt_q <= 3'h0;
      lclk_q   <= 1'b0;
    end else begin
      mem_p_q  <= !mem_p_q;
      mem_n_q  <= mem_p_q;
      lb_cnt_q <= lb_cnt_q + 3'h1;
      lclk_q   <= lclk_d;
    end
  end

  // ==========================================================
  // unit clocks
  logic [9:0]             sysc_q;
  logic                   pcidma_q;
  logic                   pcidma_en_q;
  scg_pkg::scg_ratio_type act_ratio [scg_pkg::N_UNITS];
  logic [9:0]             act_flat;

  genvar gi;
  generate
    for (gi = 0; gi < scg_pkg::N_UNITS; gi++) begin : g_unit
      scg_unit_div u_div (
        .pclk         (pclk),
        .presetn      (presetn),
        .ratio        (scg_pkg::scg_ratio_type'(sysc_q[2*gi +: 2])),
        .clk_en       (unit_clk_en[gi]),
        .ratio_active (act_ratio[gi])
      );
      assign act_flat[2*gi +: 2] = act_ratio[gi];
    end
  endgenerate

  // gating flop keeps the complex enable free of glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcidma_en_q <= 1'b0;
    end else begin
      pcidma_en_q <= pcidma_q;
    end
  end

  // ==========================================================
  // apb register file
  wire        setup    = psel && !penable;
  wire        wr_acc   = psel && penable && pwrite;
  wire        hit_outc = (paddr == scg_pkg::OFF_OUTC);
  wire        hit_sysc = (paddr == scg_pkg::OFF_SYSC);
  wire        hit_locc = (paddr == scg_pkg::OFF_LOCC);
  wire        hit_stat = (paddr == scg_pkg::OFF_STAT);
  wire        hit_rcfg = (paddr == scg_pkg::OFF_RCFG);
  wire        hit      = hit_outc || hit_sysc || hit_locc ||
                         hit_stat || hit_rcfg;
  wire [31:0] bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}},
                          {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] outc_w   = ({27'h0, outc_q} & ~bmask) | (pwdata & bmask);
  wire [31:0] sysc_w   = ({21'h0, pcidma_q, sysc_q} & ~bmask) |
                         (pwdata & bmask);
  wire [31:0] locc_w   = ({30'h0, locc_q} & ~bmask) | (pwdata & bmask);
  wire [31:0] stat_v   = {6'h00, core_cfg_invalid, core_pll_bypass,
                          core_ratio_x2, core_vco_div, csb_mult,
                          act_flat, rcw_valid};
  wire [31:0] rd_mux   =
    hit_outc ? {27'h0, outc_q} :
    hit_sysc ? {21'h0, pcidma_q, sysc_q} :
    hit_locc ? {30'h0, locc_q} :
    hit_stat ? stat_v :
    hit_rcfg ? rcw_q : 32'h0;

  logic [31:0] rdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outc_q   <= scg_pkg::OUTC_RST;
      sysc_q   <= scg_pkg::SYSC_UNITS_RST;
      pcidma_q <= scg_pkg::SYSC_PCIDMA_RST;
      locc_q   <= scg_pkg::LOCC_RST;
      rdata_q  <= 32'h0;
    end else begin
      if (wr_acc && hit_outc) begin
        outc_q <= outc_w[4:0];
      end
      if (wr_acc && hit_sysc) begin
        sysc_q   <= sysc_w[9:0];
        pcidma_q <= sysc_w[scg_pkg::SYSC_PCIDMA_BIT];
      end
      if (wr_acc && hit_locc) begin
        locc_q <= locc_w[1:0];
      end
      if (setup && !pwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // outputs
  assign pready                = 1'b1;
  assign pslverr               = psel && penable && !hit;
  assign prdata                = rdata_q;
  assign bus_sync_clk_out      = sync_out_q;
  assign bus_clk_outs          = bus_out_q;
  assign mem_bus_clock_pair_p  = mem_p_q;
  assign mem_bus_clock_pair_n  = mem_n_q;
  assign local_sync_clock_out  = lclk_q;
  assign local_bus_clock_outs  = {scg_pkg::N_LCLK{lclk_q}};
  assign pci_dma_clk_en        = pcidma_en_q;
  assign rcw_valid             = (cap_q == scg_pkg::CAP_RUN);
  assign system_pll_multiplier = sysm_q;
  assign csb_mult              = csb_mult_q;
  assign ddr_clk_mult          = ddr_mult_q;
  assign lbiu_clk_mult         = lbiu_mult_q;
  assign core_pll_bypass       = bypass_q;
  assign core_ratio_x2         = ratio_x2_q;
  assign core_vco_div          = vco_q;
  assign core_cfg_invalid      = invalid_q;

endmodule

// File: src/scg_pkg.sv
// Purpose: constants shared by the system clock generation block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   reset config word field positions are fixed here
package scg_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_OUTC = 8'h00;
  localparam logic [7:0] OFF_SYSC = 8'h04;
  localparam logic [7:0] OFF_LOCC = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_RCFG = 8'h10;

  // ==========================================================
  // sizes
  localparam int N_BUS_OUT = 5;
  localparam int N_UNITS   = 5;
  localparam int N_LCLK    = 3;

  // ==========================================================
  // unit clock ratios
  typedef enum logic [1:0] {
    RATIO_OFF   = 2'h0,
    RATIO_FULL  = 2'h1,
    RATIO_HALF  = 2'h2,
    RATIO_THIRD = 2'h3
  } scg_ratio_type;

  localparam logic [1:0] DIV_FULL  = 2'h0;
  localparam logic [1:0] DIV_HALF  = 2'h1;
  localparam logic [1:0] DIV_THIRD = 2'h2;

  // ==========================================================
  // reset values and field layout
  localparam logic [4:0]  OUTC_RST        = 5'h00;
  localparam logic [9:0]  SYSC_UNITS_RST  = 10'h3ff;
  localparam logic        SYSC_PCIDMA_RST = 1'b1;
  localparam int          SYSC_PCIDMA_BIT = 10;
  localparam logic [1:0]  LOCC_RST        = 2'h0;

  localparam logic [1:0]  LBDIV_2 = 2'h0;
  localparam logic [1:0]  LBDIV_4 = 2'h1;

  // ==========================================================
  // reset config word low layout
  localparam int RCW_SYSM_LSB  = 24;
  localparam int RCW_SYSM_W    = 4;
  localparam int RCW_CPLL_LSB  = 16;
  localparam int RCW_CPLL_W    = 7;
  localparam int RCW_MEMDB_BIT = 30;
  localparam int RCW_LBICM_BIT = 31;

  localparam int CPLL_VCO_LSB  = 0;
  localparam int CPLL_RAT_LSB  = 2;
  localparam int CPLL_HALF_BIT = 6;

  localparam logic [3:0] CORE_RAT_BYPASS = 4'h0;
  localparam logic [3:0] CORE_RAT_1      = 4'h1;
  localparam logic [3:0] CORE_RAT_2      = 4'h2;
  localparam logic [3:0] CORE_RAT_3      = 4'h3;

  localparam logic [1:0] VCO_SEL_2 = 2'h0;
  localparam logic [1:0] VCO_SEL_4 = 2'h1;
  localparam logic [3:0] VCO_DIV_2 = 4'h2;
  localparam logic [3:0] VCO_DIV_4 = 4'h4;
  localparam logic [3:0] VCO_DIV_8 = 4'h8;

  // ==========================================================
  // strap capture
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    CAP_SETTLE = 2'b01,
    CAP_RUN    = 2'b10
  } scg_cap_type;

endpackage

// File: src/scg_unit_div.sv
// Purpose: per-unit clock enable at full, half, third rate or off
// Assumes: ratio comes from a register on pclk
// Notes:   a new ratio is taken only at a period boundary
module scg_unit_div (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // control
  input  wire scg_pkg::scg_ratio_type ratio,
  // outputs
  output logic                      clk_en,
  output scg_pkg::scg_ratio_type    ratio_active
);

  // ==========================================================
  // period counter
  logic [1:0]             cnt_q;
  logic [1:0]             cnt_d;
  logic                   en_q;
  scg_pkg::scg_ratio_type cur_q;
  wire                    wrap = (cnt_q == 2'h0);
  wire  [1:0]             reload =
    (ratio == scg_pkg::RATIO_THIRD) ? scg_pkg::DIV_THIRD :
    (ratio == scg_pkg::RATIO_HALF)  ? scg_pkg::DIV_HALF  :
                                      scg_pkg::DIV_FULL;

  // switching only at a boundary keeps every pulse whole
  assign cnt_d = wrap ? reload : cnt_q - 2'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      en_q  <= 1'b0;
      cur_q <= scg_pkg::RATIO_THIRD;
    end else begin
      cnt_q <= cnt_d;
      en_q  <= wrap && (ratio != scg_pkg::RATIO_OFF);
      if (wrap) begin
        cur_q <= ratio;
      end
    end
  end

  assign clk_en       = en_q;
  assign ratio_active = cur_q;

endmodule
